// [rtl/ecpf_map.svh]
// Register offsets, field positions, reset values and counts of the engine.
// Assumes an 11-bit port-relative register address.
`ifndef ECPF_MAP_SVH
`define ECPF_MAP_SVH
`define ECPF_OFS_DATA   11'h000
`define ECPF_OFS_DCR    11'h002
`define ECPF_OFS_FIFO   11'h400
`define ECPF_OFS_ECR    11'h402
`define ECPF_OFS_EIR    11'h403
`define ECPF_OFS_EDR    11'h404
`define ECPF_IDX_PPCFG  3'h5
`define ECPF_DCR_STB    0
`define ECPF_DCR_AFD    1
`define ECPF_DCR_INIT   2
`define ECPF_DCR_SLIN   3
`define ECPF_DCR_DIR    5
`define ECPF_ECR_EMPTY  0
`define ECPF_ECR_FULL   1
`define ECPF_ECR_SVC    2
`define ECPF_ECR_DMA    3
`define ECPF_PPC_DEMAND 6
`define ECPF_PPC_USER   7
`define ECPF_CFGA_USER  3
`define ECPF_CFGA_BASE  8'h10
`define ECPF_RST_BYTE   8'h00
`define ECPF_FIFO_DEPTH 16
`define ECPF_FIFO_W     9
`define ECPF_FIFO_FREE  5'h10
`define ECPF_THRESH     5'h04
`define ECPF_BURST_LAST 2'h3
`define ECPF_FAIR_LAST  6'h1f
`define ECPF_FAIR_IDLE  4'h8
`define ECPF_FLUSH_TC   8'hff
`endif

// [rtl/ecpf_pkg.sv]
// Types shared by the engine: operating modes and write-cycle states.
// Assumes nothing beyond a SystemVerilog compiler.
package ecpf_pkg;
  typedef enum logic [2:0] {
    MODE_STD = 3'h0,
    MODE_PS2 = 3'h1,
    MODE_PPF = 3'h2,
    MODE_ECP = 3'h3,
    MODE_EPP = 3'h4,
    MODE_RSV = 3'h5,
    MODE_TST = 3'h6,
    MODE_CFG = 3'h7
  } ecpf_mode_e;
  typedef enum logic [4:0] {
    WR_IDLE  = 5'h01,
    WR_SETUP = 5'h02,
    WR_STB   = 5'h04,
    WR_HOLD  = 5'h08,
    WR_END   = 5'h10
  } ecpf_wr_e;
endpackage

// [rtl/ecpf_engine.sv]
// Parallel port transfer engine with FIFO, demand DMA and forward writes.
// Assumes one-cycle register strobes and a DMA acknowledge qualifying them.
// Summary of operation
// [RULE1] Demand DMA on: request at threshold 4 or flush expiry, unless fairness.
// [RULE2] Threshold is four free entries forward, four valid entries backward.
// [RULE3] Once raised, request stays for four transfers while FIFO can serve.
// [RULE4] After four transfers, drop on fairness or below threshold, else hold.
// [RULE5] Flush time-out is an 8-bit counter of 256 clocks raising request.
// [RULE6] Backward byte written while request low enables the flush counter.
// [RULE7] Flush counter cleared on request, forward direction or demand off.
// [RULE8] Any mode change resets the whole demand DMA mechanism and FIFO.
// [RULE9] User bit 7 of DMA config reads back as config A bit 3.
// [RULE10] Modes 000 and 001 keep FIFO empty and DMA idle.
// [RULE11] Mode 000 forces forward and drives data; 001 direction decides.
// [RULE12] Hardware cycles only in 010/011; DMA in 010, 011 and 110.
// [RULE13] Mode 010 forces forward; 011 direction bit decides data drive.
// [RULE14] Forward, FIFO not full: writes push via mode-specific FIFO ports.
// [RULE15] DMA enable set and service clear: DMA fills FIFO with data only.
// [RULE16] Forward, FIFO not empty: pop byte and tag, start a write cycle.
// [RULE17] Autofeed follows control bit 1 in 010, popped tag in 011.
// [RULE18] Cycle drives tag and byte first; strobe only after busy low.
// [RULE19] Mode 010 ends the cycle by releasing strobe without busy.
// [RULE20] Mode 011 waits busy high, then holds lines until busy low.
// [RULE21] Control pins open-drain in 000, push-pull otherwise.
// [RULE22] Mode 000 data read returns last written value, not pins.
// [RULE23] Peripheral raises busy to accept a byte, lowers it when ready.
`timescale 1ns/1ps
`include "ecpf_map.svh"

module ecpf_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk_in,
  input  wire logic                       rst_n_in,
  input  wire logic                       flush_in,
  // Fill side
  input  wire logic                       in_valid_in,
  output logic                            in_ready_out,
  input  wire logic [WIDTH-1:0]           in_data_in,
  // Drain side
  output logic                            out_valid_out,
  input  wire logic                       out_ready_in,
  output logic      [WIDTH-1:0]           out_data_out,
  output logic      [$clog2(DEPTH):0]     count_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_out != (AW+1)'(DEPTH)) && !flush_in;
  assign out_valid_out = (count_out != '0) && !flush_in;
  assign out_data_out  = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end else if (flush_in) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count_out <= '0;
    end else begin
      wr_ptr    <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr    <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count_out <= count_out + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module ecpf_engine (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [10:0] addr_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  // DMA
  output logic             drq_out,
  input  wire logic        dack_n_in,
  // Backward bytes from the peripheral read engine
  input  wire logic        rev_valid_in,
  output logic             rev_ready_out,
  input  wire logic [7:0]  rev_byte_in,
  // Peripheral pins
  input  wire logic [7:0]  pd_in,
  output logic      [7:0]  pd_out,
  output logic             pd_oe_out,
  input  wire logic        busy_in,
  output logic             strobe_n_out,
  output logic             strobe_oe_out,
  output logic             autofd_n_out,
  output logic             autofd_oe_out,
  output logic             init_n_out,
  output logic             init_oe_out,
  output logic             select_in_n_out,
  output logic             select_in_oe_out
);
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [7:0]  data_reg;
  logic [7:0]  device_control_reg;
  logic [7:0]  port_dma_config;
  logic [2:0]  eir_index;
  logic [4:2]  ecr_ctl;
  ecpf_pkg::ecpf_mode_e mode;
  ecpf_pkg::ecpf_wr_e   wr_state;
  logic        mode_chg;
  logic        dir_bwd;
  logic        sw_mode;
  logic        auto_mode;
  logic        dma_mode;
  logic        demand_en;
  logic        fifo_flush;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [8:0]  f_in_data;
  logic        f_out_valid;
  logic        f_out_ready;
  logic [8:0]  f_out_data;
  logic [4:0]  f_count;
  logic        dma_wr;
  logic        dma_rd;
  logic        dma_xfer;
  logic        sw_push;
  logic        sw_pop;
  logic        eng_pop;
  logic [7:0]  cyc_byte;
  logic        cyc_tag;
  logic        drq;
  logic [1:0]  burst;
  logic [5:0]  consec;
  logic [3:0]  idle_cnt;
  logic        fair_block;
  logic        thr_ok;
  logic        serv_ok;
  logic [7:0]  flush_cnt;
  logic        flush_en;
  logic        flush_tc;
  logic [7:0]  next_rdata;
  logic        ecr_empty;

  // A reset that arrives asynchronously but leaves in step with the clock.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  function automatic logic at_ofs(input logic [10:0] a, input logic [10:0] o);
    return a == o;
  endfunction

  // [RULE11] [RULE13] direction forcing
  assign dir_bwd = (mode == ecpf_pkg::MODE_STD || mode == ecpf_pkg::MODE_PPF)
                   ? 1'b0 : device_control_reg[`ECPF_DCR_DIR];
  // [RULE10] [RULE12] mode classes
  assign sw_mode   = (mode == ecpf_pkg::MODE_STD || mode == ecpf_pkg::MODE_PS2);
  assign auto_mode = (mode == ecpf_pkg::MODE_PPF || mode == ecpf_pkg::MODE_ECP);
  // [RULE15] DMA enable
  assign dma_mode  = (auto_mode || mode == ecpf_pkg::MODE_TST)
                     && ecr_ctl[`ECPF_ECR_DMA] && !ecr_ctl[`ECPF_ECR_SVC];
  assign demand_en = port_dma_config[`ECPF_PPC_DEMAND];
  assign mode_chg  = wr_in && dack_n_in && at_ofs(addr_in, `ECPF_OFS_ECR)
                     && (wdata_in[7:5] != mode);
  // [RULE8] [RULE10] flush
  assign fifo_flush = mode_chg || sw_mode;

  // Register writes; DMA cycles never touch the register file.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      data_reg           <= `ECPF_RST_BYTE;
      device_control_reg <= `ECPF_RST_BYTE;
      port_dma_config    <= `ECPF_RST_BYTE;
      eir_index          <= 3'h0;
      ecr_ctl            <= 3'h0;
      mode               <= ecpf_pkg::MODE_STD;
    end else if (wr_in && dack_n_in) begin
      if (at_ofs(addr_in, `ECPF_OFS_DATA)) begin
        data_reg <= wdata_in;
      end
      if (at_ofs(addr_in, `ECPF_OFS_DCR)) begin
        device_control_reg <= wdata_in;
      end
      if (at_ofs(addr_in, `ECPF_OFS_ECR)) begin
        mode    <= ecpf_pkg::ecpf_mode_e'(wdata_in[7:5]);
        ecr_ctl <= wdata_in[4:2];
      end
      if (at_ofs(addr_in, `ECPF_OFS_EIR)) begin
        eir_index <= wdata_in[2:0];
      end
      // [RULE9] user bit stored
      if (at_ofs(addr_in, `ECPF_OFS_EDR) && eir_index == `ECPF_IDX_PPCFG) begin
        port_dma_config <= wdata_in;
      end
    end
  end

  assign dma_wr   = !dack_n_in && wr_in && dma_mode && !dir_bwd;
  assign dma_rd   = !dack_n_in && rd_in && dma_mode && dir_bwd;
  assign dma_xfer = dma_wr || dma_rd;
  // [RULE14] software FIFO ports
  assign sw_push = wr_in && dack_n_in && !dir_bwd
    && ((mode == ecpf_pkg::MODE_PPF && at_ofs(addr_in, `ECPF_OFS_FIFO))
     || (mode == ecpf_pkg::MODE_ECP && (at_ofs(addr_in, `ECPF_OFS_FIFO)
                                     || at_ofs(addr_in, `ECPF_OFS_DATA))));
  assign sw_pop  = rd_in && dack_n_in && dir_bwd && mode == ecpf_pkg::MODE_ECP
                   && at_ofs(addr_in, `ECPF_OFS_FIFO);

  always_comb begin
    f_in_valid = 1'b0;
    f_in_data  = {1'b1, wdata_in};
    if (sw_push) begin
      f_in_valid = 1'b1;
      f_in_data  = {!at_ofs(addr_in, `ECPF_OFS_DATA), wdata_in};
    end else if (dma_wr) begin
      // [RULE15] DMA data tag
      f_in_valid = 1'b1;
    end else if (rev_valid_in && dir_bwd && mode == ecpf_pkg::MODE_ECP) begin
      f_in_valid = 1'b1;
      f_in_data  = {1'b1, rev_byte_in};
    end
  end
  assign rev_ready_out = f_in_ready && dir_bwd && mode == ecpf_pkg::MODE_ECP
                         && !sw_push && !dma_wr;
  assign f_out_ready = eng_pop || dma_rd || sw_pop;

  // The FIFO never stalls a host access; software watches the flags.
  ecpf_fifo #(
    .WIDTH (`ECPF_FIFO_W),
    .DEPTH (`ECPF_FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (core_clk_in),
    .rst_n_in      (rst_n),
    .flush_in      (fifo_flush),
    .in_valid_in   (f_in_valid),
    .in_ready_out  (f_in_ready),
    .in_data_in    (f_in_data),
    .out_valid_out (f_out_valid),
    .out_ready_in  (f_out_ready),
    .out_data_out  (f_out_data),
    .count_out     (f_count)
  );

  // [RULE16] pop and start
  assign eng_pop = wr_state == ecpf_pkg::WR_IDLE && auto_mode && !dir_bwd
                   && f_out_valid && !mode_chg;

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_state <= ecpf_pkg::WR_IDLE;
      cyc_byte <= `ECPF_RST_BYTE;
      cyc_tag  <= 1'b1;
    end else if (mode_chg) begin
      // A mode change abandons the cycle, so no stale byte is strobed.
      wr_state <= ecpf_pkg::WR_IDLE;
    end else begin
      case (wr_state)
        ecpf_pkg::WR_IDLE: begin
          if (eng_pop) begin
            cyc_byte <= f_out_data[7:0];
            cyc_tag  <= f_out_data[8];
            wr_state <= ecpf_pkg::WR_SETUP;
          end
        end
        // [RULE18] strobe after busy low
        ecpf_pkg::WR_SETUP: begin
          if (!busy_in) begin
            wr_state <= ecpf_pkg::WR_STB;
          end
        end
        // [RULE19] [RULE20] cycle end
        ecpf_pkg::WR_STB: begin
          if (mode != ecpf_pkg::MODE_ECP) begin
            wr_state <= ecpf_pkg::WR_END;
          end else if (busy_in) begin
            wr_state <= ecpf_pkg::WR_HOLD;
          end
        end
        ecpf_pkg::WR_HOLD: begin
          if (!busy_in) begin
            wr_state <= ecpf_pkg::WR_END;
          end
        end
        ecpf_pkg::WR_END: begin
          wr_state <= ecpf_pkg::WR_IDLE;
        end
        default: begin
          wr_state <= ecpf_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // Empty reads set only once the last cycle has finished.
  assign ecr_empty = !f_out_valid && wr_state == ecpf_pkg::WR_IDLE;

  // [RULE2] threshold
  assign thr_ok  = dir_bwd ? (f_count >= `ECPF_THRESH)
                           : ((`ECPF_FIFO_FREE - f_count) >= `ECPF_THRESH);
  // [RULE3] service check
  assign serv_ok = dir_bwd ? f_out_valid : f_in_ready;
  assign fair_block = idle_cnt != 4'h0;

  // [RULE1] [RULE3] [RULE4] request
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      drq      <= 1'b0;
      burst    <= 2'h0;
      consec   <= 6'h0;
      idle_cnt <= 4'h0;
    end else if (mode_chg || !dma_mode) begin
      // [RULE8] mechanism reset
      drq      <= 1'b0;
      burst    <= 2'h0;
      consec   <= 6'h0;
      idle_cnt <= 4'h0;
    end else if (!demand_en) begin
      drq    <= serv_ok;
      burst  <= 2'h0;
      consec <= 6'h0;
    end else if (!drq) begin
      idle_cnt <= fair_block ? idle_cnt - 4'h1 : 4'h0;
      burst    <= 2'h0;
      consec   <= 6'h0;
      drq      <= !fair_block && serv_ok && (thr_ok || flush_tc);
    end else if (!serv_ok) begin
      drq <= 1'b0;
    end else if (dma_xfer) begin
      burst  <= burst + 2'h1;
      consec <= consec + 6'h1;
      if (consec == `ECPF_FAIR_LAST) begin
        drq      <= 1'b0;
        idle_cnt <= `ECPF_FAIR_IDLE;
      end else if (burst == `ECPF_BURST_LAST && !thr_ok) begin
        drq <= 1'b0;
      end
    end
  end
  assign drq_out = drq;

  // [RULE5] [RULE6] [RULE7] flush time-out
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      flush_cnt <= 8'h00;
      flush_en  <= 1'b0;
    end else if (drq || !dir_bwd || !demand_en || mode_chg) begin
      flush_cnt <= 8'h00;
      flush_en  <= 1'b0;
    end else begin
      flush_en  <= flush_en || (rev_valid_in && rev_ready_out);
      flush_cnt <= flush_en ? flush_cnt + 8'h01 : flush_cnt;
    end
  end
  assign flush_tc = flush_en && flush_cnt == `ECPF_FLUSH_TC;

  // Read data is captured on the strobe so it stays stable after it.
  always_comb begin
    next_rdata = `ECPF_RST_BYTE;
    if (dma_rd || sw_pop) begin
      next_rdata = f_out_data[7:0];
    end else if (at_ofs(addr_in, `ECPF_OFS_DATA)) begin
      // [RULE22] latched data read
      next_rdata = dir_bwd ? pd_in : data_reg;
    end else if (at_ofs(addr_in, `ECPF_OFS_DCR)) begin
      next_rdata = {device_control_reg[7:6], dir_bwd,
                    device_control_reg[4:0]};
    end else if (at_ofs(addr_in, `ECPF_OFS_ECR)) begin
      // Full comes from the count, since ready also drops while flushing.
      next_rdata = {mode, ecr_ctl, f_count == `ECPF_FIFO_FREE, ecr_empty};
    end else if (at_ofs(addr_in, `ECPF_OFS_EIR)) begin
      next_rdata = {5'h00, eir_index};
    end else if (at_ofs(addr_in, `ECPF_OFS_EDR)
                 && eir_index == `ECPF_IDX_PPCFG) begin
      next_rdata = port_dma_config;
    end else if (at_ofs(addr_in, `ECPF_OFS_FIFO)
                 && mode == ecpf_pkg::MODE_CFG) begin
      // [RULE9] user bit readback
      next_rdata = `ECPF_CFGA_BASE | {4'h0,
        port_dma_config[`ECPF_PPC_USER], 3'h0};
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= `ECPF_RST_BYTE;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end
  end

  // Pin levels come from flops; in open-drain mode a high is only released.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pd_out          <= `ECPF_RST_BYTE;
      strobe_n_out    <= 1'b1;
      autofd_n_out    <= 1'b1;
      init_n_out      <= 1'b0;
      select_in_n_out <= 1'b1;
    end else begin
      init_n_out      <= device_control_reg[`ECPF_DCR_INIT];
      select_in_n_out <= !device_control_reg[`ECPF_DCR_SLIN];
      if (auto_mode && !dir_bwd) begin
        pd_out       <= cyc_byte;
        strobe_n_out <= wr_state != ecpf_pkg::WR_STB;
        // [RULE17] autofeed source
        autofd_n_out <= (mode == ecpf_pkg::MODE_ECP) ? cyc_tag
                        : !device_control_reg[`ECPF_DCR_AFD];
      end else begin
        pd_out       <= data_reg;
        strobe_n_out <= !device_control_reg[`ECPF_DCR_STB];
        autofd_n_out <= !device_control_reg[`ECPF_DCR_AFD];
      end
    end
  end

  // [RULE11] [RULE13] data drive
  assign pd_oe_out = !dir_bwd;
  // [RULE21] open-drain controls
  assign strobe_oe_out    = mode != ecpf_pkg::MODE_STD || !strobe_n_out;
  assign autofd_oe_out    = mode != ecpf_pkg::MODE_STD || !autofd_n_out;
  assign init_oe_out      = mode != ecpf_pkg::MODE_STD || !init_n_out;
  assign select_in_oe_out = mode != ecpf_pkg::MODE_STD || !select_in_n_out;

  a_mode_flush: assert property (  // [RULE8]
    @(posedge core_clk_in) disable iff (!rst_n)
    mode_chg |=> f_count == 5'h00 && !drq && flush_cnt == 8'h00)
    else $error("mode change left DMA or FIFO state");
  a_sw_idle: assert property (  // [RULE10]
    @(posedge core_clk_in) disable iff (!rst_n)
    sw_mode |-> f_count == 5'h00 && !drq)
    else $error("FIFO or DMA active in software mode");
  a_dir_forced: assert property (  // [RULE11]
    @(posedge core_clk_in) disable iff (!rst_n)
    (mode == ecpf_pkg::MODE_STD || mode == ecpf_pkg::MODE_PPF)
    |-> pd_oe_out)
    else $error("data pins not driven in forward-only mode");
  a_strobe_busy: assert property (  // [RULE18]
    @(posedge core_clk_in) disable iff (!rst_n)
    $past(auto_mode && !dir_bwd) && $fell(strobe_n_out)
    |-> $past(!busy_in, 2))
    else $error("strobe asserted without busy low");
  a_hold_lines: assert property (  // [RULE20]
    @(posedge core_clk_in) disable iff (!rst_n)
    wr_state == ecpf_pkg::WR_HOLD && !dir_bwd && $past(!dir_bwd)
    |=> $stable(pd_out) && $stable(autofd_n_out))
    else $error("lines changed before busy low");
  a_flush_clear: assert property (  // [RULE7]
    @(posedge core_clk_in) disable iff (!rst_n)
    drq || !dir_bwd |=> flush_cnt == 8'h00 && !flush_en)
    else $error("flush counter not cleared");
  a_burst_hold: assert property (  // [RULE3]
    @(posedge core_clk_in) disable iff (!rst_n)
    drq && demand_en && dma_xfer && burst != `ECPF_BURST_LAST
    && consec != `ECPF_FAIR_LAST && serv_ok && dma_mode && !mode_chg
    |=> drq)
    else $error("request dropped inside a burst");
  a_od_pins: assert property (  // [RULE21]
    @(posedge core_clk_in) disable iff (!rst_n)
    mode == ecpf_pkg::MODE_STD && strobe_n_out |-> !strobe_oe_out)
    else $error("strobe driven high in open-drain mode");
endmodule

// [test/ecpf_periph.sv]
// Peripheral model that answers the forward write handshake with busy.
// Assumes active-low strobe and autofeed pin levels from the engine.
`timescale 1ns/1ps
module ecpf_periph (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Engine pins
  input  wire logic       strobe_n_in,
  input  wire logic       autofd_n_in,
  input  wire logic [7:0] pd_in,
  output logic            busy_out,
  // Test control and capture
  input  wire logic       stall_in,
  input  wire logic [1:0] dly_in,
  output logic      [7:0] byte_out,
  output logic            tag_out,
  output logic      [7:0] count_out
);
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out  <= 1'b0;
      wait_cnt  <= 2'h0;
      byte_out  <= 8'h00;
      tag_out   <= 1'b0;
      count_out <= 8'h00;
    end else begin
      if (!strobe_n_in && !busy_out && wait_cnt == 2'h0) begin
        byte_out  <= pd_in;
        tag_out   <= autofd_n_in;
        count_out <= count_out + 8'h01;
      end
      // Busy follows strobe.
      // A stall parks busy high so the engine must hold its byte.
      if (stall_in) begin
        busy_out <= 1'b1;
        wait_cnt <= 2'h0;
      end else if (busy_out == strobe_n_in) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == dly_in) begin
          busy_out <= !busy_out;
          wait_cnt <= 2'h0;
        end
      end else begin
        wait_cnt <= 2'h0;
      end
    end
  end
endmodule

// [test/ecp_fifo_transfer_engine_test.sv]
// Self-checking bench for the transfer engine with a peripheral model.
// Assumes registers and DMA are driven on the falling clock edge.
`timescale 1ns/1ps
module ecp_fifo_transfer_engine_test;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [10:0] addr = 11'h000;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rv_byte = 8'h99;
  logic [7:0]  rdata, pd, p_byte, p_cnt;
  logic        wr = 1'b0, rd = 1'b0, dack_n = 1'b1, rv = 1'b0, stall = 1'b0;
  logic        drq, rr, pd_oe, busy, sn, so, an, ao, inn, io, ln, lo, p_tag;
  logic [1:0]  dly = 2'h0;
  int          failures = 0;
  int          checked = 0;
  int          n;

  ecpf_engine i_ecpf_engine (
    .core_clk_in(clk), .rstn_in(rstn), .addr_in(addr), .wr_in(wr),
    .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata), .drq_out(drq),
    .dack_n_in(dack_n), .rev_valid_in(rv), .rev_ready_out(rr),
    .rev_byte_in(rv_byte), .pd_in(8'h3c), .pd_out(pd), .pd_oe_out(pd_oe),
    .busy_in(busy), .strobe_n_out(sn), .strobe_oe_out(so),
    .autofd_n_out(an), .autofd_oe_out(ao), .init_n_out(inn),
    .init_oe_out(io), .select_in_n_out(ln), .select_in_oe_out(lo));

  ecpf_periph i_ecpf_periph (
    .clk_in(clk), .rst_n_in(rstn), .strobe_n_in(sn), .autofd_n_in(an),
    .pd_in(pd), .busy_out(busy), .stall_in(stall), .dly_in(dly),
    .byte_out(p_byte), .tag_out(p_tag), .count_out(p_cnt));

  always #20 clk = ~clk;

  task automatic conclude();
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk1(input string what, input logic seen, input logic exp);
    chk(what, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wr_reg(input logic [10:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [10:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
  endtask

  task automatic chk_reg(input string what, input logic [10:0] a,
                         input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk(what, v, exp);
  endtask

  task automatic dma(input logic w, input logic [7:0] d);
    @(negedge clk);
    dack_n = 1'b0;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge clk);
    dack_n = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
  endtask

  // Pushes one byte and waits until the write engine is idle again.
  task automatic send(input logic [10:0] a, input logic [7:0] d,
                      input logic [7:0] cnt, input logic t);
    logic [7:0] v;
    wr_reg(a, d);
    v = 8'h00;
    for (int i = 0; i < 60 && !v[0]; i++) rd_reg(11'h402, v);
    chk("count", p_cnt, cnt);
    chk("byte", p_byte, d);
    chk1("tag", p_tag, t);
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk1("drq", drq, 1'b0);
    chk1("stb_oe", so, 1'b0);
    chk1("afd_oe", ao, 1'b0);
    chk1("slin_oe", lo, 1'b0);
    chk1("slin", ln, 1'b1);
    chk1("init", inn, 1'b0);
    chk1("init_oe", io, 1'b1);
    wr_reg(11'h002, 8'h21);
    repeat (2) @(negedge clk);
    chk1("stb_oe", so, 1'b1);
    chk1("pd_oe", pd_oe, 1'b1);
    wr_reg(11'h000, 8'ha5);
    chk_reg("data", 11'h000, 8'ha5);
    wr_reg(11'h400, 8'h11);
    chk_reg("ecr", 11'h402, 8'h01);
    wr_reg(11'h402, 8'h20);
    wr_reg(11'h002, 8'h20);
    repeat (2) @(negedge clk);
    chk1("pd_oe", pd_oe, 1'b0);
    chk1("stb_oe", so, 1'b1);
    chk1("slin_oe", lo, 1'b1);
    chk1("afd_oe", ao, 1'b1);
    wr_reg(11'h403, 8'h05);
    wr_reg(11'h404, 8'h80);
    chk_reg("dma_cfg", 11'h404, 8'h80);
    wr_reg(11'h402, 8'he0);
    chk_reg("cfg_a", 11'h400, 8'h18);
    wr_reg(11'h404, 8'h00);
    chk_reg("cfg_a", 11'h400, 8'h10);
    chk_reg("unmapped", 11'h7ff, 8'h00);
    // Slow busy proves mode 010 never waits for busy high.
    // The software strobe in mode 000 already gave the peripheral one byte.
    dly = 2'h3;
    wr_reg(11'h402, 8'h40);
    wr_reg(11'h002, 8'h22);
    repeat (2) @(negedge clk);
    chk1("pd_oe", pd_oe, 1'b1);
    send(11'h400, 8'h77, 8'h02, 1'b0);
    dly = 2'h2;
    wr_reg(11'h002, 8'h00);
    wr_reg(11'h402, 8'h60);
    send(11'h000, 8'h12, 8'h03, 1'b0);
    send(11'h400, 8'h34, 8'h04, 1'b1);
    stall = 1'b1;
    wr_reg(11'h404, 8'h40);
    wr_reg(11'h402, 8'h68);
    for (int i = 0; i < 8 && !drq; i++) @(negedge clk);
    chk1("drq_up", drq, 1'b1);
    n = 0;
    while (drq && n < 40) begin
      dma(1'b1, n[7:0]);
      n++;
      @(negedge clk);
      if (n % 4 != 0) chk1("drq_hold", drq, 1'b1);
    end
    chk("burst", n[7:0], 8'h10);
    wr_reg(11'h402, 8'h08);
    stall = 1'b0;
    wr_reg(11'h402, 8'h68);
    repeat (3) @(negedge clk);
    chk1("drq_flush", drq, 1'b1);
    wr_reg(11'h002, 8'h20);
    repeat (3) @(negedge clk);
    chk1("drq_back", drq, 1'b0);
    chk1("pd_oe", pd_oe, 1'b0);
    // Ready is looked at settled; one rising edge then takes the byte.
    rv = 1'b1;
    for (int i = 0; i < 20 && !rr; i++) @(negedge clk);
    @(negedge clk);
    rv = 1'b0;
    n = 0;
    while (!drq && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk1("flush_lo", n > 240, 1'b1);
    chk1("flush_hi", n < 270, 1'b1);
    dma(1'b0, 8'h00);
    chk("dma_rd", rdata, 8'h99);
    @(negedge clk);
    chk1("drq_empty", drq, 1'b0);
    conclude();
  end
endmodule
